// file: verilog/dpram_pkg.sv
package dpram_pkg;
  // ---------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W     = 14;
  localparam int unsigned DATA_W     = 9;
  localparam int unsigned DEPTH      = 16384;
  localparam logic [13:0] ADDR_ZERO  = 14'h0000;
  localparam logic [13:0] ADDR_ONE   = 14'h0001;
  localparam logic [8:0]  DATA_RESET = 9'h000;
  // ---------------------------------------------------------------
  // Host register map (APB, byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_ADDR    = 8'h04;
  localparam logic [7:0] REG_WDATA   = 8'h08;
  localparam logic [7:0] REG_CMD     = 8'h0C;
  localparam logic [7:0] REG_RDATA   = 8'h10;
  localparam logic [7:0] REG_STATUS  = 8'h14;
  // CTRL fields
  localparam int unsigned CTRL_SEL_BIT  = 0;
  localparam int unsigned CTRL_PIPE_BIT = 1;
  localparam int unsigned CTRL_OE_BIT   = 2;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0005;
  // CMD codes
  localparam logic [2:0] CMD_READ    = 3'h1;
  localparam logic [2:0] CMD_WRITE   = 3'h2;
  localparam logic [2:0] CMD_RD_NEXT = 3'h3;
  localparam logic [2:0] CMD_WR_NEXT = 3'h4;
  localparam logic [2:0] CMD_CLEAR   = 3'h5;
  localparam logic [2:0] CMD_IDLE    = 3'h6;
  // Cycles from issuing a read to sampling data (registered + pipe)
  localparam logic [1:0] RD_WAIT_FLOW = 2'h2;
  localparam logic [1:0] RD_WAIT_PIPE = 2'h3;
endpackage

// file: verilog/dpram_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dpram_if;
  logic       clk;
  logic       chip_select_active_low;
  logic       chip_select_active_high;
  logic       address_load_strobe_n;
  logic       counter_advance_n;
  logic       counter_clear_n;
  logic       write_n;
  logic       output_enable_n;
  logic       output_latency_select;
  logic [13:0] addr;
  logic [8:0] wdata;
  logic [8:0] dq_out;
  logic       dq_oe;
  wire  [8:0] dq_bus = dq_oe ? dq_out : wdata;

  modport ram (
    input  clk, chip_select_active_low, chip_select_active_high, address_load_strobe_n,
    input  counter_advance_n, counter_clear_n, write_n, output_enable_n,
    input  output_latency_select, addr, wdata,
    output dq_out, dq_oe
  );
  modport ctl (
    output clk, chip_select_active_low, chip_select_active_high, address_load_strobe_n,
    output counter_advance_n, counter_clear_n, write_n, output_enable_n,
    output output_latency_select, addr, wdata,
    input  dq_out, dq_oe
  );
endinterface
`default_nettype wire

// file: verilog/ram_port.sv
`timescale 1ns/1ps
`default_nettype none
// One port's input registers, address counter and output path
module ram_port
  import dpram_pkg::*;
(
  input  wire logic              clk_i,       // Port clock
  input  wire logic              rst_n_i,     // Sync reset
  input  wire logic              ce_i,        // Clock enable
  input  wire logic              cs_n_i,      // Active-low select
  input  wire logic              cs_i,        // Active-high select
  input  wire logic              load_n_i,    // Address load strobe
  input  wire logic              adv_n_i,     // Counter advance
  input  wire logic              clr_n_i,     // Counter clear
  input  wire logic              we_n_i,      // Write, active low
  input  wire logic              oe_n_i,      // Async output enable
  input  wire logic              pipe_i,      // Output latency select
  input  wire logic [ADDR_W-1:0] addr_i,      // External address
  input  wire logic [DATA_W-1:0] wdata_i,     // Write data
  input  wire logic [DATA_W-1:0] rd_array_i,  // Array word at acc_addr_o
  output logic      [ADDR_W-1:0] acc_addr_o,  // Registered access address
  output logic                   wr_en_o,     // Registered write strobe
  output logic      [DATA_W-1:0] wr_data_o,   // Registered write data
  output logic      [DATA_W-1:0] dq_o,        // Output data
  output logic                   dq_oe_o      // Output drive enable
);
  logic [ADDR_W-1:0] cnt_q;
  logic [ADDR_W-1:0] cnt_d;
  logic              sel;
  logic              rd_q;
  logic              rd_pipe_q;
  logic              act_q;
  logic              act2_q;
  logic [DATA_W-1:0] pipe_q;

  assign sel = ~cs_n_i & cs_i;

  // ---------------------------------------------------------------
  // Address counter
  // ---------------------------------------------------------------
  always_comb begin
    if (!clr_n_i) begin
      cnt_d = ADDR_ZERO;
    end else if (!load_n_i) begin
      cnt_d = addr_i;
    end else if (!adv_n_i) begin
      cnt_d = acc_addr_o + ADDR_ONE;
    end else begin
      cnt_d = acc_addr_o;
    end
  end

  // All inputs except oe_n_i and pipe_i registered on the rising edge; the array write then
  // happens from registered values, standing in for the self-timed pulse
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q     <= ADDR_ZERO;
      wr_en_o   <= 1'b0;
      wr_data_o <= DATA_RESET;
      rd_q      <= 1'b0;
    end else if (ce_i) begin
      cnt_q     <= cnt_d;
      wr_en_o   <= sel & ~we_n_i;
      wr_data_o <= wdata_i;
      rd_q      <= sel & we_n_i;
    end
  end
  assign acc_addr_o = cnt_q;

  // ---------------------------------------------------------------
  // Output stage
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pipe_q    <= DATA_RESET;
      rd_pipe_q <= 1'b0;
      act_q     <= 1'b0;
      act2_q    <= 1'b0;
    end else if (ce_i) begin
      pipe_q    <= rd_array_i;
      rd_pipe_q <= rd_q;
      act_q     <= sel;
      act2_q    <= act_q & sel;
    end
  end

  // Flow-through shows the array word directly, pipelined adds a stage
  assign dq_o    = pipe_i ? pipe_q : rd_array_i;
  assign dq_oe_o = ~oe_n_i & (pipe_i ? (rd_pipe_q & act2_q) : rd_q);
endmodule
`default_nettype wire

// file: verilog/dpram_dev.sv
`timescale 1ns/1ps
`default_nettype none
module dpram_dev
  import dpram_pkg::*;
(
  input  wire logic CORE_CLK_I,   // Array clock
  input  wire logic RESETN_I,     // Sync reset, active low
  input  wire logic CE_I,         // Clock enable
  dpram_if.ram      PORT_A,       // Port A pins
  dpram_if.ram      PORT_B        // Port B pins
);
  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [ADDR_W-1:0] addr_a;
  logic [ADDR_W-1:0] addr_b;
  logic              we_a;
  logic              we_b;
  logic [DATA_W-1:0] wd_a;
  logic [DATA_W-1:0] wd_b;

  // ---------------------------------------------------------------
  // Two identical ports
  // ---------------------------------------------------------------
  ram_port u_port_a (
    .clk_i      (CORE_CLK_I),
    .rst_n_i    (RESETN_I),
    .ce_i       (CE_I),
    .cs_n_i     (PORT_A.chip_select_active_low),
    .cs_i       (PORT_A.chip_select_active_high),
    .load_n_i   (PORT_A.address_load_strobe_n),
    .adv_n_i    (PORT_A.counter_advance_n),
    .clr_n_i    (PORT_A.counter_clear_n),
    .we_n_i     (PORT_A.write_n),
    .oe_n_i     (PORT_A.output_enable_n),
    .pipe_i     (PORT_A.output_latency_select),
    .addr_i     (PORT_A.addr),
    .wdata_i    (PORT_A.wdata),
    .rd_array_i (mem_q[addr_a]),
    .acc_addr_o (addr_a),
    .wr_en_o    (we_a),
    .wr_data_o  (wd_a),
    .dq_o       (PORT_A.dq_out),
    .dq_oe_o    (PORT_A.dq_oe)
  );

  ram_port u_port_b (
    .clk_i      (CORE_CLK_I),
    .rst_n_i    (RESETN_I),
    .ce_i       (CE_I),
    .cs_n_i     (PORT_B.chip_select_active_low),
    .cs_i       (PORT_B.chip_select_active_high),
    .load_n_i   (PORT_B.address_load_strobe_n),
    .adv_n_i    (PORT_B.counter_advance_n),
    .clr_n_i    (PORT_B.counter_clear_n),
    .we_n_i     (PORT_B.write_n),
    .oe_n_i     (PORT_B.output_enable_n),
    .pipe_i     (PORT_B.output_latency_select),
    .addr_i     (PORT_B.addr),
    .wdata_i    (PORT_B.wdata),
    .rd_array_i (mem_q[addr_b]),
    .acc_addr_o (addr_b),
    .wr_en_o    (we_b),
    .wr_data_o  (wd_b),
    .dq_o       (PORT_B.dq_out),
    .dq_oe_o    (PORT_B.dq_oe)
  );

  // ---------------------------------------------------------------
  // Array write; same-address collision lets port A win
  // ---------------------------------------------------------------
  // One shared clock means the writer's data is visible to the other
  // port's read on the next edge, well inside the port-to-port delay
  always_ff @(posedge CORE_CLK_I) begin
    if (CE_I) begin
      if (we_b) begin
        mem_q[addr_b] <= wd_b;
      end
      if (we_a) begin
        mem_q[addr_a] <= wd_a;
      end
    end
  end
endmodule
`default_nettype wire

// file: verilog/dpram_ctl.sv
`timescale 1ns/1ps
`default_nettype none
// APB-driven controller for one RAM port
module dpram_ctl
  import dpram_pkg::*;
(
  input  wire logic        CORE_CLK_I,  // Clock
  input  wire logic        RESETN_I,    // Sync reset, active low
  input  wire logic        CE_I,        // Clock enable
  input  wire logic        PSEL_I,      // APB select
  input  wire logic        PENABLE_I,   // APB enable
  input  wire logic        PWRITE_I,    // APB direction
  input  wire logic [7:0]  PADDR_I,     // APB address
  input  wire logic [31:0] PWDATA_I,    // APB write data
  output logic      [31:0] PRDATA_O,    // APB read data
  output logic             PREADY_O,    // APB ready
  output logic             PSLVERR_O,   // APB error
  dpram_if.ctl             RAM          // RAM port pins
);
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_ISSUE = 2'b01, S_WAIT = 2'b11} state_t;
  state_t      state_q;
  logic [31:0] ctrl_q;
  logic [13:0] addr_q;
  logic [8:0]  wdata_q;
  logic [2:0]  cmd_q;
  logic [8:0]  rdata_q;
  logic [1:0]  wait_q;
  logic        acc;
  logic        wr;
  logic        busy;

  assign acc       = PSEL_I & PENABLE_I;
  assign wr        = acc & PWRITE_I;
  assign busy      = (state_q != S_IDLE);
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = acc & ~(PADDR_I == REG_CTRL || PADDR_I == REG_ADDR ||
                             PADDR_I == REG_WDATA || PADDR_I == REG_CMD ||
                             PADDR_I == REG_RDATA || PADDR_I == REG_STATUS);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      ctrl_q  <= CTRL_RESET;
      addr_q  <= ADDR_ZERO;
      wdata_q <= DATA_RESET;
    end else if (CE_I && wr && !busy) begin
      if (PADDR_I == REG_CTRL) ctrl_q <= PWDATA_I;
      if (PADDR_I == REG_ADDR) addr_q <= PWDATA_I[13:0];
      if (PADDR_I == REG_WDATA) wdata_q <= PWDATA_I[8:0];
    end
  end

  always_comb begin
    unique case (PADDR_I)
      REG_CTRL:   PRDATA_O = ctrl_q;
      REG_ADDR:   PRDATA_O = {18'h00000, addr_q};
      REG_WDATA:  PRDATA_O = {23'h000000, wdata_q};
      REG_CMD:    PRDATA_O = {29'h00000000, cmd_q};
      REG_RDATA:  PRDATA_O = {23'h000000, rdata_q};
      REG_STATUS: PRDATA_O = {31'h00000000, busy};
      default:    PRDATA_O = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Command sequencer: one RAM cycle per command
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      state_q <= S_IDLE;
      cmd_q   <= 3'h0;
      wait_q  <= 2'h0;
      rdata_q <= DATA_RESET;
    end else if (CE_I) begin
      unique case (state_q)
        S_IDLE: if (wr && PADDR_I == REG_CMD) begin
          cmd_q   <= PWDATA_I[2:0];
          state_q <= S_ISSUE;
        end
        S_ISSUE: begin
          wait_q  <= ctrl_q[CTRL_PIPE_BIT] ? RD_WAIT_PIPE : RD_WAIT_FLOW;
          state_q <= S_WAIT;
        end
        S_WAIT: begin
          if (wait_q == 2'h1) begin
            if (cmd_q == CMD_READ || cmd_q == CMD_RD_NEXT) rdata_q <= RAM.dq_out;
            state_q <= S_IDLE;
          end
          wait_q <= wait_q - 2'h1;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin drive; selects assert while a command is issued, the active-low one
  // only for commands other than CMD_IDLE, and in pipelined mode through the wait as well, since the
  // outputs only come back after two selected cycles. An idle port powers down.
  // Rewrites after a turnaround are left to software, which owns
  // the location list.
  // ---------------------------------------------------------------
  logic issue;
  logic drive;
  assign issue = (state_q == S_ISSUE);
  assign drive = issue | ((state_q == S_WAIT) & ctrl_q[CTRL_PIPE_BIT]);
  assign RAM.clk                     = CORE_CLK_I;
  assign RAM.output_latency_select   = ctrl_q[CTRL_PIPE_BIT];
  assign RAM.output_enable_n         = ~ctrl_q[CTRL_OE_BIT];
  assign RAM.chip_select_active_low  = ~(drive & ctrl_q[CTRL_SEL_BIT] & cmd_q != CMD_IDLE);
  assign RAM.chip_select_active_high = drive & ctrl_q[CTRL_SEL_BIT];
  assign RAM.address_load_strobe_n   = ~(issue & (cmd_q == CMD_READ || cmd_q == CMD_WRITE));
  assign RAM.counter_advance_n       = ~(issue & (cmd_q == CMD_RD_NEXT || cmd_q == CMD_WR_NEXT));
  assign RAM.counter_clear_n         = ~(issue & cmd_q == CMD_CLEAR);
  assign RAM.write_n                 = ~(issue & (cmd_q == CMD_WRITE || cmd_q == CMD_WR_NEXT));
  assign RAM.addr                    = addr_q;
  assign RAM.wdata                   = wdata_q;
endmodule
`default_nettype wire

// file: testbench/dpram_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dpram_port_asserts (
  input wire logic        clk,                     // Port clock
  input wire logic        RESETN_I,                // Reset, low
  input wire logic        chip_select_active_low,  // Select, low
  input wire logic        chip_select_active_high, // Select, high
  input wire logic        address_load_strobe_n,   // Load
  input wire logic        counter_advance_n,       // Advance
  input wire logic        counter_clear_n,         // Clear
  input wire logic        write_n,                 // Write
  input wire logic        output_enable_n,         // Async enable
  input wire logic        output_latency_select,   // 1 = pipelined
  input wire logic [13:0] addr,                    // Address
  input wire logic [8:0]  wdata,                   // Write data
  input wire logic [8:0]  dq_out,                  // Read data
  input wire logic        dq_oe                    // Drive enable
);
  logic        sel;
  logic        last_ok_q;
  logic [13:0] last_addr_q;
  logic [8:0]  last_data_q;
  assign sel = !chip_select_active_low && chip_select_active_high;
  // ------------------------------------------------------------
  // Last loaded write; counter writes spoil it, as address unseen
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!RESETN_I) begin
      last_ok_q <= 1'b0;
    end else if (sel && !write_n) begin
      last_ok_q <= counter_clear_n && !address_load_strobe_n;
    end
  end
  always_ff @(posedge clk) begin
    if (sel && !write_n) begin
      last_addr_q <= addr;
      last_data_q <= wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!RESETN_I);
  // Counter hold does not depend on select, so idle stretches count too
  sequence s_hold;
    address_load_strobe_n && counter_advance_n && counter_clear_n && write_n
      && !output_latency_select;
  endsequence
  sequence s_rd_hit;
    sel && !address_load_strobe_n && counter_clear_n && write_n && last_ok_q
      && addr == last_addr_q;
  endsequence
  property p_oe_async;
    output_enable_n |-> !dq_oe;
  endproperty
  property p_deselect;
    !sel |=> !dq_oe;
  endproperty
  property p_prev_sel;
    dq_oe |-> $past(sel);
  endproperty
  property p_pipe_two;
    dq_oe && output_latency_select && $past(output_latency_select) |-> $past(sel, 2);
  endproperty
  property p_flow_on;
    sel && write_n && !output_latency_select ##1 !output_enable_n && !output_latency_select
      |-> dq_oe;
  endproperty
  property p_hold;
    s_hold [*3] |-> dq_out === $past(dq_out);
  endproperty
  property p_flow_rd;
    (s_rd_hit and !output_latency_select) ##1 !output_enable_n && !output_latency_select
      |-> dq_oe && dq_out == last_data_q;
  endproperty
  property p_pipe_rd;
    (s_rd_hit and output_latency_select) ##1 write_n && output_latency_select
      ##1 output_latency_select |-> dq_out == last_data_q;
  endproperty
  a_oe_async: assert property (p_oe_async) else $error("drive with enable off");
  a_deselect: assert property (p_deselect) else $error("drive after deselect");
  a_prev_sel: assert property (p_prev_sel) else $error("drive without select");
  a_pipe_two: assert property (p_pipe_two) else $error("pipe drive too early");
  a_flow_on: assert property (p_flow_on) else $error("flow output not driven");
  a_hold: assert property (p_hold) else $error("data moved during hold");
  a_flow_rd: assert property (p_flow_rd) else $error("flow read data wrong");
  a_pipe_rd: assert property (p_pipe_rd) else $error("pipe read data wrong");
endmodule
`default_nettype wire

// file: testbench/sync_dual_port_ram_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sync_dual_port_ram_port_tb;
  import dpram_pkg::*;
  logic        core_clk  = 1'b0;
  logic        resetn    = 1'b0;
  logic [1:0]  psel      = 2'h0;
  logic [1:0]  penable   = 2'h0;
  logic [1:0]  pwrite    = 2'h0;
  logic [7:0]  paddr[2]  = '{8'h00, 8'h00};
  logic [31:0] pwdata[2] = '{32'h0, 32'h0};
  logic [31:0] prdata[2];
  logic [1:0]  pready;
  logic [1:0]  pslverr;
  int          error_cnt = 0;
  int          checked   = 0;
  dpram_if ia ();
  dpram_if ib ();
  // Each controller drives its own port's clock pin
  always #2.5 core_clk = ~core_clk;
  dpram_dev dpram_dev_inst (.CORE_CLK_I(core_clk), .RESETN_I(resetn), .CE_I(1'b1),
    .PORT_A(ia), .PORT_B(ib));
  dpram_ctl dpram_ctl_inst (.CORE_CLK_I(core_clk), .RESETN_I(resetn), .CE_I(1'b1),
    .PSEL_I(psel[0]), .PENABLE_I(penable[0]), .PWRITE_I(pwrite[0]), .PADDR_I(paddr[0]),
    .PWDATA_I(pwdata[0]), .PRDATA_O(prdata[0]), .PREADY_O(pready[0]),
    .PSLVERR_O(pslverr[0]), .RAM(ia));
  dpram_ctl dpram_ctl_b_inst (.CORE_CLK_I(core_clk), .RESETN_I(resetn), .CE_I(1'b1),
    .PSEL_I(psel[1]), .PENABLE_I(penable[1]), .PWRITE_I(pwrite[1]), .PADDR_I(paddr[1]),
    .PWDATA_I(pwdata[1]), .PRDATA_O(prdata[1]), .PREADY_O(pready[1]),
    .PSLVERR_O(pslverr[1]), .RAM(ib));
  dpram_port_asserts dpram_port_asserts_inst (.clk(ia.clk), .RESETN_I(resetn),
    .chip_select_active_low(ia.chip_select_active_low),
    .chip_select_active_high(ia.chip_select_active_high),
    .address_load_strobe_n(ia.address_load_strobe_n),
    .counter_advance_n(ia.counter_advance_n), .counter_clear_n(ia.counter_clear_n),
    .write_n(ia.write_n), .output_enable_n(ia.output_enable_n),
    .output_latency_select(ia.output_latency_select), .addr(ia.addr),
    .wdata(ia.wdata), .dq_out(ia.dq_out), .dq_oe(ia.dq_oe));
  task end_sim();
    $display("Checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  task apb(input int p, input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic err);
    int n;
    @(posedge core_clk);
    psel[p] <= 1'b1;
    pwrite[p] <= wr;
    paddr[p] <= a;
    pwdata[p] <= d;
    @(posedge core_clk);
    penable[p] <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready[p] !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("pready_wait", 32'h1, 32'h0);
      end_sim();
    end
    rd = prdata[p];
    err = pslverr[p];
    psel[p] <= 1'b0;
    penable[p] <= 1'b0;
  endtask
  task wreg(input int p, input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(p, 1'b1, a, d, r, e);
  endtask
  // Busy is polled, since register writes are dropped while it is set
  task op(input int p, input logic [2:0] c, input logic [13:0] a, input logic [8:0] d,
          output logic [31:0] r);
    int   n;
    logic e;
    wreg(p, REG_ADDR, {18'h0, a});
    wreg(p, REG_WDATA, {23'h0, d});
    wreg(p, REG_CMD, {29'h0, c});
    n = 0;
    do begin
      apb(p, 1'b0, REG_STATUS, 32'h0, r, e);
      n++;
    end while (r[0] !== 1'b0 && n < 20);
    if (n >= 20) begin
      chk("busy_wait", 32'h1, 32'h0);
      end_sim();
    end
    apb(p, 1'b0, REG_RDATA, 32'h0, r, e);
    r = {23'h0, r[8:0]};
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task s_cross();
    logic [31:0] r;
    op(0, CMD_WRITE, 14'h0005, 9'h1A5, r);
    op(0, CMD_READ, 14'h0005, 9'h000, r);
    chk("a_rd_0005", r, 32'h1A5);
    op(1, CMD_READ, 14'h0005, 9'h000, r);
    chk("b_rd_0005", r, 32'h1A5);
    op(1, CMD_WRITE, 14'h3FFF, 9'h05A, r);
    op(0, CMD_READ, 14'h3FFF, 9'h000, r);
    chk("a_rd_3fff", r, 32'h05A);
  endtask
  task s_counter();
    logic [31:0] r;
    op(0, CMD_WRITE, 14'h0010, 9'h111, r);
    op(0, CMD_WR_NEXT, 14'h0010, 9'h122, r);
    op(1, CMD_READ, 14'h0011, 9'h000, r);
    chk("b_rd_0011", r, 32'h122);
    op(0, CMD_READ, 14'h0010, 9'h000, r);
    op(0, CMD_RD_NEXT, 14'h0000, 9'h000, r);
    chk("a_rd_next", r, 32'h122);
    op(0, CMD_WRITE, 14'h3FFF, 9'h1C3, r);
    op(0, CMD_WR_NEXT, 14'h3FFF, 9'h03C, r);
    op(1, CMD_READ, 14'h0000, 9'h000, r);
    chk("b_rd_wrap", r, 32'h03C);
    op(0, CMD_WRITE, 14'h0001, 9'h0E1, r);
    op(0, CMD_READ, 14'h0123, 9'h000, r);
    op(0, CMD_CLEAR, 14'h0123, 9'h03C, r);
    op(0, CMD_RD_NEXT, 14'h0123, 9'h000, r);
    chk("a_rd_clear", r, 32'h0E1);
  endtask
  task s_pipe();
    logic [31:0] r;
    wreg(0, REG_CTRL, 32'h0000_0007);
    op(0, CMD_READ, 14'h0005, 9'h000, r);
    chk("a_pipe_0005", r, 32'h1A5);
    op(1, CMD_READ, 14'h0010, 9'h000, r);
    chk("b_flow_0010", r, 32'h111);
    op(0, CMD_IDLE, 14'h0000, 9'h000, r);
    op(0, CMD_WRITE, 14'h0001, 9'h0E1, r);
    op(0, CMD_READ, 14'h0001, 9'h000, r);
    chk("a_pipe_0001", r, 32'h0E1);
    wreg(0, REG_CTRL, 32'h0000_0001);
    op(0, CMD_READ, 14'h0005, 9'h000, r);
    chk("a_oe_off_0005", r, 32'h1A5);
    wreg(0, REG_CTRL, 32'h0000_0005);
  endtask
  task s_regs();
    logic [31:0] r;
    logic        e;
    apb(0, 1'b0, REG_CTRL, 32'h0, r, e);
    chk("ctrl_reset", r, CTRL_RESET);
    apb(0, 1'b0, 8'h18, 32'h0, r, e);
    chk("unmapped_data", r, 32'h0);
    chk("unmapped_err", {31'h0, e}, 32'h1);
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    s_regs();
    s_cross();
    s_counter();
    s_pipe();
    end_sim();
  end
endmodule
`default_nettype wire
